// ===== sapc_map.svh
`ifndef SAPC_MAP_SVH
`define SAPC_MAP_SVH

// ==========================================================
// Register indexes on the plain register port
`define SAPC_ADDR_MAIN 4'h0
`define SAPC_ADDR_RC 4'h1
`define SAPC_ADDR_CLK 4'h2
`define SAPC_ADDR_IST 4'h3
`define SAPC_ADDR_IMSK 4'h4

// ==========================================================
// Reset values
`define SAPC_MAIN_RST 16'h0000
`define SAPC_RC_RST 16'h0000
`define SAPC_CLK_RST 16'h0000
`define SAPC_IRQ_RST 3'h0

// ==========================================================
// Field positions
`define SAPC_F_FMT_HI 2
`define SAPC_F_FMT_LO 0
`define SAPC_F_BPOL 3
`define SAPC_F_FPOL 4
`define SAPC_F_TDM16 5
`define SAPC_F_SEL_HI 6
`define SAPC_F_SEL_LO 5
`define SAPC_F_MUXEN 8
`define SAPC_F_LOCK 7
`define SAPC_F_MCOEN 6
`define SAPC_F_MCO_HI 5
`define SAPC_F_MCO_LO 3
`define SAPC_F_CKSEL_HI 2
`define SAPC_F_CKSEL_LO 0

// Writable bits of the main, converter and clock registers
`define SAPC_MAIN_WMASK 16'h003f
`define SAPC_RC_WMASK 16'h007f
`define SAPC_CLK_WMASK 16'h017f

// ==========================================================
// Format codes, last slot and bit indexes and interrupt bits
`define SAPC_FMT_PULSE 3'h2
`define SAPC_FMT_TDM 3'h3
`define SAPC_SLOT_LAST 5'd31
`define SAPC_SLOTS_PULSE 4'd1
`define SAPC_SLOTS_TDM8 4'd7
`define SAPC_SLOTS_TDM16 4'd15
`define SAPC_MCO_CODES 3'h4
`define SAPC_IRQ_LOCK_UP 0
`define SAPC_IRQ_LOCK_DN 1
`define SAPC_IRQ_FRAME 2

`endif

// ===== sapc_pkg.sv
`default_nettype none
package sapc_pkg;

    // ==========================================================
    // Framing modes of a receive port
    typedef enum logic [2:0] {
        SAPC_STEREO = 3'b001,
        SAPC_PULSE = 3'b010,
        SAPC_TDM = 3'b100
    } sapc_mode_t;

    // One received channel word
    typedef struct packed {
        logic valid;
        logic [3:0] chan;
        logic [31:0] data;
    } sapc_word_t;

    // Framing step result
    typedef struct packed {
        logic first;
        logic start;
        logic active;
        logic [3:0] chan;
        logic [4:0] bits;
    } sapc_frm_t;

    typedef struct packed {
        logic [31:0] shift;
        logic [31:0] word;
        logic done;
    } sapc_lane_st_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] filt;
        logic [7:0] fprev;
        logic [15:0] main_ctl;
        logic [15:0] rc_ctl;
        logic [15:0] clk_ctl;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic [15:0] rdata;
        logic lock_prev;
        logic m_lrc;
        logic m_active;
        logic [3:0] m_chan;
        logic [4:0] m_bits;
        logic [3:0] m_emit_ch;
        logic m_emit_ok;
        logic a_lrc;
        logic a_active;
        logic [3:0] a_chan;
        logic [4:0] a_bits;
        logic [3:0] a_emit_ch;
        logic a_emit_ok;
        logic [3:0] mco_cnt;
        logic mco;
        sapc_word_t [3:0] dsp;
        sapc_word_t src;
    } sapc_top_st_t;

endpackage : sapc_pkg
`default_nettype wire

// ===== sapc_rx_lane.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_rx_lane import sapc_pkg::*; (
    input wire logic clk_i,          // System clock
    input wire logic rst_n_i,        // Synchronous reset, active low
    input wire logic ce_i,           // Clock enable
    input wire logic cap_i,          // Capture strobe, one cycle
    input wire logic first_i,        // This bit opens a new word
    input wire logic bit_i,          // Filtered serial data bit
    output logic [31:0] word_o,      // Last completed word
    output logic done_o              // Word completed, one cycle
);

    sapc_lane_st_t s_q;
    sapc_lane_st_t s_d;

    // ==========================================================
    // Shift register, MSB arrives first
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (cap_i) begin
            if (first_i) begin
                s_d.word = s_q.shift;
                s_d.done = 1'b1;
                s_d.shift = {31'h0, bit_i};
            end else begin
                s_d.shift = {s_q.shift[30:0], bit_i};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign word_o = s_q.word;
    assign done_o = s_q.done;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_lane_handover: assert property (ce_i && cap_i && first_i
        |=> done_o && word_o == $past(s_q.shift) && s_q.shift == {31'h0, $past(bit_i)})
        else $error("lane word not handed over");

    a_lane_msb_first: assert property (ce_i && cap_i && !first_i
        |=> s_q.shift == {$past(s_q.shift[30:0]), $past(bit_i)})
        else $error("lane bits not shifted MSB first");

endmodule : sapc_rx_lane
`default_nettype wire

// ===== sapc_top.sv
// Overview of operation
// - Stereo: frame clock level picks left/right
// - TDM starts after chosen frame clock edge
// - Pulse frame: first pulse edge starts frame
// - Bit clock polarity picks capture edge
// - Polarity bits apply in every format
// - Two-bit field routes input to converter
// - Converter port left/right by frame level
// - Converter bit clock polarity picks edge
// - Converter port refuses TDM formats
// - Mux enable swaps direct input for converter
// - Read-only converter lock status bit
// - Master clock output driven when enabled with divider codes 0 to 3
// - TDM mode bit picks 8 or 16 slots
`timescale 1ns/1ps
`default_nettype none
`include "sapc_map.svh"
module sapc_top import sapc_pkg::*; (
    input wire logic clk_i,                  // 25 MHz system clock
    input wire logic rst_n_i,                // Synchronous reset, active low
    input wire logic ce_i,                   // Clock enable, freezes state when low
    input wire logic [3:0] reg_addr_i,       // Register index
    input wire logic [15:0] reg_wdata_i,     // Register write data
    input wire logic reg_we_i,               // Write strobe
    input wire logic reg_re_i,               // Read strobe
    output logic [15:0] reg_rdata_o,         // Read data, cycle after strobe
    input wire logic main_bit_clock_i,       // Main port bit clock pin
    input wire logic main_frame_clock_i,     // Main port frame clock pin
    input wire logic aux_bit_clock_i,        // Converter port bit clock pin
    input wire logic aux_frame_clock_i,      // Converter port frame clock pin
    input wire logic [3:0] serial_data_inputs_i, // Serial data pins
    input wire logic rc_lock_i,              // Converter lock level
    input wire sapc_word_t rc_ret_i,         // Converter output words
    output sapc_word_t src_o,                // Words sent to the converter
    output sapc_word_t [3:0] dsp_o,          // Words for the DSP core, per input
    output logic master_clock_output_o,      // Master clock output pin
    output logic [2:0] clk_sel_o,            // Master clock input select
    output logic irq_o                       // Interrupt, level, active high
);

    sapc_top_st_t s_q;
    sapc_top_st_t s_d;

    // ==========================================================
    // Helpers
    function automatic sapc_mode_t fmt_mode(input logic [2:0] fmt, input logic allow_tdm);
        sapc_mode_t m;
        m = SAPC_STEREO;
        if (fmt == `SAPC_FMT_PULSE) begin
            m = SAPC_PULSE;
        end else if (fmt == `SAPC_FMT_TDM && allow_tdm) begin
            m = SAPC_TDM;
        end
        return m;
    endfunction : fmt_mode

    // One capture edge of framing; lr is the frame clock at this edge
    function automatic sapc_frm_t frm_step(input sapc_mode_t mode, input logic fpol,
                                           input logic tdm16, input logic lr, input logic lrc,
                                           input logic active, input logic [3:0] chan,
                                           input logic [4:0] bits);
        sapc_frm_t f;
        logic [3:0] last;
        f = '0;
        f.active = active;
        f.chan = chan;
        f.bits = bits + 5'd1;
        last = (mode == SAPC_PULSE) ? `SAPC_SLOTS_PULSE :
               (tdm16 ? `SAPC_SLOTS_TDM16 : `SAPC_SLOTS_TDM8);
        case (mode)
            SAPC_STEREO: begin
                f.first = (lr != lrc);
                if (f.first) begin
                    f.active = 1'b1;
                    f.chan = {3'h0, lr ^ fpol};
                    f.bits = 5'd0;
                end
            end
            SAPC_PULSE, SAPC_TDM: begin
                f.start = (lr != lrc) && (lr == fpol);
                f.first = f.start || (active && bits == `SAPC_SLOT_LAST);
                if (f.start) begin
                    f.active = 1'b1;
                    f.chan = 4'h0;
                    f.bits = 5'd0;
                end else if (f.first) begin
                    f.bits = 5'd0;
                    if (chan == last) begin
                        f.active = 1'b0;
                    end else begin
                        f.chan = chan + 4'h1;
                    end
                end
            end
            default: begin
                f.first = 1'b0;
            end
        endcase
        return f;
    endfunction : frm_step

    function automatic logic [15:0] reg_read(input logic [3:0] addr, input sapc_top_st_t s,
                                             input logic lock);
        logic [15:0] v;
        v = 16'h0000;
        case (addr)
            `SAPC_ADDR_MAIN: v = s.main_ctl;
            `SAPC_ADDR_RC: v = s.rc_ctl;
            `SAPC_ADDR_CLK: begin
                v = s.clk_ctl;
                v[`SAPC_F_LOCK] = lock;
            end
            `SAPC_ADDR_IST: v = {13'h0000, s.ist};
            `SAPC_ADDR_IMSK: v = {13'h0000, s.imsk};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : reg_read

    // ==========================================================
    // Decoded controls
    sapc_mode_t m_mode;
    sapc_mode_t a_mode;
    logic m_bpol;
    logic m_fpol;
    logic a_bpol;
    logic a_fpol;
    logic [1:0] rc_sel;
    logic mux_en;
    logic [2:0] mco_code;
    logic m_cap;
    logic a_cap;
    sapc_frm_t m_frm;
    sapc_frm_t a_frm;
    logic [4:0] cap;
    logic [4:0] first;
    logic [4:0] lane_bit;
    logic [31:0] word [0:4];
    logic [4:0] done;
    logic [2:0] ev;

    always_comb begin
        m_mode = fmt_mode(s_q.main_ctl[`SAPC_F_FMT_HI:`SAPC_F_FMT_LO], 1'b1);
        a_mode = fmt_mode(s_q.rc_ctl[`SAPC_F_FMT_HI:`SAPC_F_FMT_LO], 1'b0);
        m_bpol = s_q.main_ctl[`SAPC_F_BPOL];
        m_fpol = s_q.main_ctl[`SAPC_F_FPOL];
        a_bpol = s_q.rc_ctl[`SAPC_F_BPOL];
        a_fpol = s_q.rc_ctl[`SAPC_F_FPOL];
        rc_sel = s_q.rc_ctl[`SAPC_F_SEL_HI:`SAPC_F_SEL_LO];
        mux_en = s_q.clk_ctl[`SAPC_F_MUXEN];
        mco_code = s_q.clk_ctl[`SAPC_F_MCO_HI:`SAPC_F_MCO_LO];
    end

    // ==========================================================
    // Capture edges: data moves on one bit clock edge, taken on the other
    assign m_cap = ce_i && (s_q.filt[0] != s_q.fprev[0]) && (s_q.filt[0] == ~m_bpol);
    assign a_cap = ce_i && (s_q.filt[2] != s_q.fprev[2]) && (s_q.filt[2] == ~a_bpol);

    assign m_frm = frm_step(m_mode, m_fpol, s_q.main_ctl[`SAPC_F_TDM16], s_q.filt[1],
                            s_q.m_lrc, s_q.m_active, s_q.m_chan, s_q.m_bits);
    assign a_frm = frm_step(a_mode, a_fpol, 1'b0, s_q.filt[3],
                            s_q.a_lrc, s_q.a_active, s_q.a_chan, s_q.a_bits);

    // ==========================================================
    // Lanes: four direct inputs and the converter feed
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cap[i] = m_cap;
            first[i] = m_frm.first;
            lane_bit[i] = s_q.filt[4 + i];
        end
        cap[4] = a_cap;
        first[4] = a_frm.first;
        lane_bit[4] = s_q.filt[3'd4 + {1'b0, rc_sel}];
    end

    for (genvar g = 0; g < 5; g++) begin : g_lane
        sapc_rx_lane u_lane (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .cap_i(cap[g]),
            .first_i(first[g]),
            .bit_i(lane_bit[g]),
            .word_o(word[g]),
            .done_o(done[g])
        );
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        // Pin filter: a level counts once stages two and three agree
        s_d.s1 = {serial_data_inputs_i, aux_frame_clock_i, aux_bit_clock_i,
                  main_frame_clock_i, main_bit_clock_i};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.filt = (s_q.s2 & ~(s_q.s2 ^ s_q.s3)) | (s_q.filt & (s_q.s2 ^ s_q.s3));
        s_d.fprev = s_q.filt;

        if (m_cap) begin
            s_d.m_lrc = s_q.filt[1];
            s_d.m_active = m_frm.active;
            s_d.m_chan = m_frm.chan;
            s_d.m_bits = m_frm.bits;
            if (m_frm.first) begin
                s_d.m_emit_ch = s_q.m_chan;
                s_d.m_emit_ok = s_q.m_active;
            end
        end
        if (a_cap) begin
            s_d.a_lrc = s_q.filt[3];
            s_d.a_active = a_frm.active;
            s_d.a_chan = a_frm.chan;
            s_d.a_bits = a_frm.bits;
            if (a_frm.first) begin
                s_d.a_emit_ch = s_q.a_chan;
                s_d.a_emit_ok = s_q.a_active;
            end
        end

        // Words go out the cycle after the lane finishes them
        for (int i = 0; i < 4; i++) begin
            if (mux_en && rc_sel == i[1:0]) begin
                s_d.dsp[i] = rc_ret_i;
            end else begin
                s_d.dsp[i] = {done[i] && s_q.m_emit_ok, s_q.m_emit_ch, word[i]};
            end
        end
        s_d.src = {done[4] && s_q.a_emit_ok && mux_en, s_q.a_emit_ch, word[4]};

        // Master clock output: divide by 2, 4, 8 or 16; other codes stay low
        s_d.mco_cnt = s_q.mco_cnt + 4'h1;
        s_d.mco = s_q.clk_ctl[`SAPC_F_MCOEN] && (mco_code < `SAPC_MCO_CODES)
                  && s_q.mco_cnt[mco_code[1:0]];

        // Events and sticky status; a new event beats a clear in the same cycle
        ev[`SAPC_IRQ_LOCK_UP] = rc_lock_i && !s_q.lock_prev;
        ev[`SAPC_IRQ_LOCK_DN] = !rc_lock_i && s_q.lock_prev;
        ev[`SAPC_IRQ_FRAME] = m_cap && m_frm.start;
        s_d.lock_prev = rc_lock_i;
        s_d.ist = s_q.ist;
        if (reg_we_i && reg_addr_i == `SAPC_ADDR_IST) begin
            s_d.ist = s_q.ist & ~reg_wdata_i[2:0];
        end
        s_d.ist = s_d.ist | ev;

        // Register writes; the six low main bits are taken together
        if (reg_we_i) begin
            case (reg_addr_i)
                `SAPC_ADDR_MAIN: s_d.main_ctl = reg_wdata_i & `SAPC_MAIN_WMASK;
                `SAPC_ADDR_RC: s_d.rc_ctl = reg_wdata_i & `SAPC_RC_WMASK;
                `SAPC_ADDR_CLK: s_d.clk_ctl = reg_wdata_i & `SAPC_CLK_WMASK;
                `SAPC_ADDR_IMSK: s_d.imsk = reg_wdata_i[2:0];
                default: s_d.imsk = s_q.imsk;
            endcase
        end
        s_d.rdata = reg_re_i ? reg_read(reg_addr_i, s_q, rc_lock_i) : 16'h0000;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.main_ctl <= `SAPC_MAIN_RST;
            s_q.rc_ctl <= `SAPC_RC_RST;
            s_q.clk_ctl <= `SAPC_CLK_RST;
            s_q.ist <= `SAPC_IRQ_RST;
            s_q.imsk <= `SAPC_IRQ_RST;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o = s_q.rdata;
    assign dsp_o = s_q.dsp;
    assign src_o = s_q.src;
    assign master_clock_output_o = s_q.mco;
    // Frequency select for the clock generator; software keeps it matched to the input
    assign clk_sel_o = s_q.clk_ctl[`SAPC_F_CKSEL_HI:`SAPC_F_CKSEL_LO];
    assign irq_o = |(s_q.ist & s_q.imsk);

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_stereo_side: assert property (m_cap && m_mode == SAPC_STEREO && m_frm.first
        |=> s_q.m_chan == {3'h0, $past(s_q.filt[1]) ^ $past(m_fpol)})
        else $error("main stereo channel side wrong");

    a_tdm_start: assert property (m_cap && m_mode == SAPC_TDM
        && s_q.filt[1] != s_q.m_lrc && s_q.filt[1] == m_fpol
        |=> s_q.m_chan == 4'h0 && s_q.m_bits == 5'd0 && s_q.m_active)
        else $error("TDM frame did not restart");

    a_pulse_edge: assert property (m_cap && m_mode == SAPC_PULSE
        && s_q.filt[1] != s_q.m_lrc && s_q.filt[1] != m_fpol
        |=> !(s_q.m_active && s_q.m_chan == 4'h0 && s_q.m_bits == 5'd0))
        else $error("pulse frame started on wrong edge");

    a_cap_edge: assert property (m_cap |-> $past(s_q.filt[0]) == m_bpol)
        else $error("main capture on wrong bit clock edge");

    a_fmt_tdm: assert property (s_q.main_ctl[2:0] == `SAPC_FMT_TDM |-> m_mode == SAPC_TDM)
        else $error("format field not decoded");

    a_src_lane: assert property (a_cap |-> lane_bit[4] == s_q.filt[4 + rc_sel])
        else $error("converter input routed from wrong pin");

    a_aux_side: assert property (src_o.valid |-> src_o.chan[3:1] == 3'h0)
        else $error("converter channel out of stereo range");

    a_aux_edge: assert property (a_cap |-> $past(s_q.filt[2]) == a_bpol)
        else $error("converter capture on wrong edge");

    a_no_tdm_src: assert property (a_mode != SAPC_TDM)
        else $error("converter port took TDM framing");

    a_mux_block: assert property ($past(ce_i) && $past(mux_en) && dsp_o[rc_sel].valid
        && $past(rc_sel) == rc_sel |-> $past(rc_ret_i.valid))
        else $error("direct input not blocked under mux");

    a_lock_read: assert property (ce_i && reg_re_i && reg_addr_i == `SAPC_ADDR_CLK
        |=> reg_rdata_o[`SAPC_F_LOCK] == $past(rc_lock_i))
        else $error("lock status bit wrong");

    a_mco_off: assert property (ce_i && !s_q.clk_ctl[`SAPC_F_MCOEN]
        |=> !master_clock_output_o)
        else $error("master clock output active while disabled");

    a_tdm8_slots: assert property (m_cap && m_mode == SAPC_TDM && m_frm.first
        && !s_q.main_ctl[`SAPC_F_TDM16] && !m_frm.start && s_q.m_chan == `SAPC_SLOTS_TDM8
        |=> !s_q.m_active)
        else $error("TDM slot count overran");

    a_read_once: assert property ($past(ce_i) && !$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside its cycle");

    c_tdm_frame: cover property (m_cap && m_mode == SAPC_TDM && m_frm.start);
    c_src_word: cover property (src_o.valid);
    c_dsp_word: cover property (dsp_o[0].valid && !mux_en);
    c_irq: cover property (irq_o);

endmodule : sapc_top
`default_nettype wire

// ===== sapc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial source: lead-in bit, one stereo frame, one closing bit
module sapc_src_model (
    input wire logic run_i,          // Start one frame
    input wire logic bpol_i,         // Bit clock polarity
    input wire logic fpol_i,         // Frame clock polarity
    input wire logic [31:0] l_i,     // Left word
    input wire logic [31:0] r_i,     // Right word
    output logic bclk_o,             // Bit clock, still outside frames
    output logic lrc_o,              // Frame clock
    output logic [3:0] sd_o,         // Data, word on lane 1, inverse on the others
    output logic busy_o              // Frame in progress
);
    logic [63:0] w;
    initial begin
        bclk_o = 1'b1;
        lrc_o = 1'b0;
        sd_o = 4'h0;
        busy_o = 1'b0;
    end
    always @(posedge run_i) begin
        w = {l_i, r_i};
        busy_o = 1'b1;
        #7;
        for (int i = 0; i < 66; i++) begin
            bclk_o = bpol_i; // Data moves on the change edge only
            lrc_o = fpol_i ^ (i == 0 || (i > 32 && i < 65)); // Left level equals polarity
            // Only lane 1 carries the word as sent, the others its inverse, so a wrong route shows
            sd_o = {4{w[(128 - i) % 64]}} ^ 4'hd; // MSB first
            #160;
            bclk_o = ~bpol_i;
            #160;
        end
        sd_o = ~sd_o; // Released line must not keep showing the last bit
        busy_o = 1'b0;
    end
endmodule : sapc_src_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sapc_map.svh"
module tb import sapc_pkg::*; ;
    logic clk_i = 1'b0, rst_n_i = 1'b0, we = 1'b0, re = 1'b0, lock = 1'b0, ce = 1'b1;
    logic [3:0] adr = 4'h0;
    logic [15:0] wd = 16'h0, rdat;
    sapc_word_t ret = '0, src;
    sapc_word_t [3:0] dsp;
    logic mco, irq, route = 1'b0, p_run = 1'b0, p_bp = 1'b0, p_fp = 1'b0, p_bc, p_lr, p_busy;
    logic [2:0] cks;
    logic [31:0] p_l = 32'h0, p_r = 32'h0;
    logic [3:0] p_sd;
    logic [31:0] got [0:2];
    logic [31:0] sgot [0:1];
    int num_errors = 0, tests_run = 0;

    always #20 clk_i = ~clk_i;

    // ==========================================================
    // Design and source; route moves the source to the converter port
    sapc_top sapc_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .reg_addr_i(adr), .reg_wdata_i(wd),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat),
        .main_bit_clock_i(route ? 1'b1 : p_bc), .main_frame_clock_i(route ? 1'b0 : p_lr),
        .aux_bit_clock_i(route ? p_bc : 1'b1), .aux_frame_clock_i(route ? p_lr : 1'b0),
        .serial_data_inputs_i(p_sd), .rc_lock_i(lock), .rc_ret_i(ret), .src_o(src),
        .dsp_o(dsp), .master_clock_output_o(mco), .clk_sel_o(cks), .irq_o(irq)
    );
    sapc_src_model sapc_src_model_i (
        .run_i(p_run), .bpol_i(p_bp), .fpol_i(p_fp), .l_i(p_l), .r_i(p_r),
        .bclk_o(p_bc), .lrc_o(p_lr), .sd_o(p_sd), .busy_o(p_busy)
    );

    always @(posedge clk_i) begin
        if (dsp[0].valid === 1'b1) got[dsp[0].chan[0]] <= dsp[0].data;
        if (dsp[1].valid === 1'b1) got[2] <= dsp[1].data;
        if (src.valid === 1'b1) sgot[src.chan[0]] <= src.data;
    end

    // ==========================================================
    // Shared tasks
    task automatic give_verdict;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        adr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1 d = rdat;
    endtask : rd
    task automatic frame(input logic bp, fp, input logic [31:0] l, r);
        int n;
        @(posedge clk_i);
        p_bp <= bp;
        p_fp <= fp;
        p_l <= l;
        p_r <= r;
        p_run <= 1'b1;
        @(posedge clk_i);
        p_run <= 1'b0;
        for (n = 0; n < 1000; n++) begin
            @(posedge clk_i);
            if (p_busy === 1'b0) break;
        end
        if (n == 1000) begin
            num_errors++;
            $display("[ERR] frame wait ran out");
            give_verdict();
        end
        repeat (12) @(posedge clk_i);
    endtask : frame

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [15:0] d;
        logic [15:0] m [0:4] = '{16'h003f, 16'h007f, 16'h017f, 16'h0000, 16'h0007};
        for (int a = 0; a < 6; a++) begin
            rd(a[3:0], d);
            chk("reset value", d, 16'h0);
            wr(a[3:0], 16'hffff);
            rd(a[3:0], d);
            chk("writable bits", d, (a < 5) ? m[a] : 16'h0);
            wr(a[3:0], 16'h0);
        end
        ce <= 1'b0;
        wr(`SAPC_ADDR_IMSK, 16'h0007);
        ce <= 1'b1;
        rd(`SAPC_ADDR_IMSK, d);
        chk("write frozen by enable", d, 16'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_irq;
        logic [15:0] d;
        @(posedge clk_i);
        lock <= 1'b1;
        rd(`SAPC_ADDR_CLK, d);
        chk("lock bit", d, 16'h0080);
        rd(`SAPC_ADDR_IST, d);
        chk("status lock rise", d, 16'h0001);
        chk("irq masked", irq, 1'b0);
        wr(`SAPC_ADDR_IMSK, 16'h0003);
        #1 chk("irq unmasked", irq, 1'b1);
        wr(`SAPC_ADDR_IST, 16'h0001);
        #1 chk("irq cleared", irq, 1'b0);
        @(posedge clk_i);
        lock <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk("irq lock fall", irq, 1'b1);
        wr(`SAPC_ADDR_IST, 16'h0002);
        wr(`SAPC_ADDR_IMSK, 16'h0000);
        $display("test irq done");
    endtask : t_irq
    task automatic t_mco;
        logic v;
        wr(`SAPC_ADDR_CLK, 16'h0045); // Valid divider code, select matches input
        repeat (4) @(posedge clk_i);
        #1 v = mco;
        @(posedge clk_i);
        #1 chk("mco divide by two", mco, !v);
        chk("clock select", cks, 3'h5);
        wr(`SAPC_ADDR_CLK, 16'h0005); // Output disabled, divider code left valid
        repeat (4) @(posedge clk_i);
        #1 chk("mco disabled low", mco, 1'b0);
        wr(`SAPC_ADDR_CLK, 16'h0000);
        $display("test mco done");
    endtask : t_mco
    task automatic t_stereo(input logic [2:0] fmt, input logic bp, fp, input logic [31:0] l, r);
        logic [15:0] d;
        wr(`SAPC_ADDR_MAIN, {11'h0, fp, bp, fmt}); // Polarity bits with the format
        frame(bp, fp, l, r);
        chk("left word", got[0], ~l);
        chk("right word", got[1], ~r);
        rd(`SAPC_ADDR_IST, d);
        chk("frame start flag", d, (fmt == 3'h0) ? 16'h0000 : 16'h0004);
        wr(`SAPC_ADDR_IST, 16'h0004);
        $display("test frame done");
    endtask : t_stereo
    task automatic t_mux;
        @(posedge clk_i);
        route <= 1'b1;
        wr(`SAPC_ADDR_RC, 16'h0023); // Lane 1; TDM code must act as stereo
        wr(`SAPC_ADDR_CLK, 16'h0100);
        frame(1'b0, 1'b0, 32'h0f0f_5555, 32'h7e81_0c3a);
        chk("converter left", sgot[0], 32'h0f0f_5555);
        chk("converter right", sgot[1], 32'h7e81_0c3a);
        @(posedge clk_i);
        ret <= {1'b1, 4'h0, 32'h5a5a_0001};
        @(posedge clk_i);
        ret <= '0;
        repeat (3) @(posedge clk_i);
        chk("converter return", got[2], 32'h5a5a_0001);
        wr(`SAPC_ADDR_CLK, 16'h0000);
        route <= 1'b0;
        $display("test mux done");
    endtask : t_mux

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        t_regs();
        t_irq();
        t_mco();
        t_stereo(3'h0, 1'b0, 1'b0, 32'hc350_0a5f, 32'h1234_abcd);
        t_stereo(3'h0, 1'b1, 1'b1, 32'h3caf_f5a0, 32'hedcb_5432);
        t_stereo(`SAPC_FMT_TDM, 1'b0, 1'b0, 32'h9d21_47e6, 32'h05b8_c3f1);
        t_stereo(`SAPC_FMT_PULSE, 1'b1, 1'b1, 32'h6e4a_1b97, 32'hf013_8d2c);
        t_mux();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
